// ==== rtl/frame_trigger_control.sv ====
// Frame trigger controller with an AXI4-Lite register slave
//
// Operation
// - Single kind: one frame per accepted trigger
// - Burst kind: several consecutive frames per trigger
// - Burst total sets frames, burst only
// - Enable switch gates the trigger
// - Software fire triggers regardless of origin
// - Origin matters only when enabled
// - Link origin uses grabber trigger line
// - Software origin ignores all hardware lines
// - Timer origin uses timer one expiry
// - Counter origin uses counter one expiry
// - Sense qualifies only the external line
// - Rise sense: low-to-high after inversion
// - Fall sense: high-to-low after inversion
// - Both-edge sense: any transition
// - High-level sense: valid while high
// - Low-level sense: valid while low
// - Wait programmed microseconds before firing
// - Policy off: none while frame active
// - Readout policy: accept once exposure ends, whether or not readout has begun
// - Exposure-end policy: accept after exposure
// - Exposure-end policy: latch and postpone if readout unfinished
// - Link trigger line is a selectable line
// - Disabled triggering: timers pace free run
// - Policy off: ignore during exposure plus readout
// - Synchronous alignment: early trigger flags invalid unless a level sense is set or readout is busy
`timescale 1ns/1ps
module frame_trigger_control
    import trig_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trigger sources
    input wire logic link_trigger_line,
    input wire logic timer_one_expiry,
    input wire logic counter_one_expiry,
    // Sensor timing
    input wire logic readout_begin,
    input wire logic readout_done,
    // Frame control out
    output logic exposure_start,
    output logic exposure_active,
    output logic invalid_trigger_event
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus slave

    logic [31:0] ctrl_q;
    logic [15:0] burst_frame_total_q;
    logic [23:0] fire_latency_q;
    logic [31:0] free_period_q;
    logic [31:0] free_expo_q;
    logic sw_fire_command_q;
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic [31:0] invalid_count_q;
    logic [15:0] frames_left_q;
    fsm_t state_q;
    logic readout_busy_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= 8'h00;
            aw_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_held_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_held_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Register writes; the fire command is a one-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            burst_frame_total_q <= BURST_RST;
            fire_latency_q <= DELAY_RST;
            free_period_q <= FREE_PERIOD_RST;
            free_expo_q <= FREE_EXPO_RST;
            sw_fire_command_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            sw_fire_command_q <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                unique case (awaddr_q)
                    CTRL_OFS: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
                    BURST_OFS: burst_frame_total_q <=
                        16'(merge({16'h0000, burst_frame_total_q}, wdata_q, wstrb_q));
                    DELAY_OFS: fire_latency_q <=
                        24'(merge({8'h00, fire_latency_q}, wdata_q, wstrb_q));
                    FIRE_OFS: sw_fire_command_q <= wstrb_q[0] && wdata_q[0];
                    FREE_PERIOD_OFS: free_period_q <= merge(free_period_q, wdata_q, wstrb_q);
                    FREE_EXPO_OFS: free_expo_q <= merge(free_expo_q, wdata_q, wstrb_q);
                    STATUS_OFS: s_axi_bresp <= 2'b10;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                             (!s_axi_rvalid && !s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                unique case (s_axi_araddr)
                    CTRL_OFS: s_axi_rdata <= ctrl_q;
                    BURST_OFS: s_axi_rdata <= {16'h0000, burst_frame_total_q};
                    DELAY_OFS: s_axi_rdata <= {8'h00, fire_latency_q};
                    FIRE_OFS: s_axi_rdata <= 32'h0000_0000;
                    STATUS_OFS: s_axi_rdata <= {invalid_count_q[11:0], frames_left_q,
                                               readout_busy_q, state_q[2:0]};
                    FREE_PERIOD_OFS: s_axi_rdata <= free_period_q;
                    FREE_EXPO_OFS: s_axi_rdata <= free_expo_q;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and trigger qualification

    logic [1:0] line_sync_q, timer_sync_q, counter_sync_q, rb_sync_q, rd_sync_q;
    logic line_prev_q, timer_prev_q, counter_prev_q, rb_prev_q, rd_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_sync_q <= 2'b00;
            timer_sync_q <= 2'b00;
            counter_sync_q <= 2'b00;
            rb_sync_q <= 2'b00;
            rd_sync_q <= 2'b00;
            line_prev_q <= 1'b0;
            timer_prev_q <= 1'b0;
            counter_prev_q <= 1'b0;
            rb_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end else begin
            line_sync_q <= {line_sync_q[0], link_trigger_line};
            timer_sync_q <= {timer_sync_q[0], timer_one_expiry};
            counter_sync_q <= {counter_sync_q[0], counter_one_expiry};
            rb_sync_q <= {rb_sync_q[0], readout_begin};
            rd_sync_q <= {rd_sync_q[0], readout_done};
            line_prev_q <= line_sync_q[1];
            timer_prev_q <= timer_sync_q[1];
            counter_prev_q <= counter_sync_q[1];
            rb_prev_q <= rb_sync_q[1];
            rd_prev_q <= rd_sync_q[1];
        end
    end

    wire kind_burst = ctrl_q[KIND_BIT];
    wire trigger_enable_switch = ctrl_q[ENABLE_BIT];
    wire [1:0] trigger_origin_select = ctrl_q[ORIGIN_LSB +: 2];
    wire [2:0] trigger_sense_kind = ctrl_q[SENSE_LSB +: 3];
    wire [1:0] retrigger_policy = ctrl_q[POLICY_LSB +: 2];
    wire line_invert = ctrl_q[INVERT_BIT];
    wire sync_align = ctrl_q[SYNC_ALIGN_BIT];

    // Inversion applies before any edge or level test
    wire line_now = line_sync_q[1] ^ line_invert;
    wire line_was = line_prev_q ^ line_invert;
    wire rb_pulse = rb_sync_q[1] && !rb_prev_q;
    wire rd_pulse = rd_sync_q[1] && !rd_prev_q;

    logic line_hit, level_mode, origin_hit, trig_req;
    always_comb begin
        line_hit = 1'b0;
        level_mode = 1'b0;
        unique case (trigger_sense_kind)
            SENSE_RISE: line_hit = line_now && !line_was;
            SENSE_FALL: line_hit = !line_now && line_was;
            SENSE_BOTH: line_hit = line_now != line_was;
            SENSE_HIGH: begin
                line_hit = line_now;
                level_mode = 1'b1;
            end
            SENSE_LOW: begin
                line_hit = !line_now;
                level_mode = 1'b1;
            end
            default: line_hit = 1'b0;
        endcase
        // Sense only touches the line origin
        unique case (trigger_origin_select)
            ORG_LINK: origin_hit = line_hit;
            ORG_SW: origin_hit = 1'b0;
            ORG_TIMER: origin_hit = timer_sync_q[1] && !timer_prev_q;
            ORG_COUNTER: origin_hit = counter_sync_q[1] && !counter_prev_q;
            default: origin_hit = 1'b0;
        endcase
        // Origin counts only with the switch on; software fire always does
        trig_req = sw_fire_command_q || (trigger_enable_switch && origin_hit);
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencing

    logic [31:0] count_q;
    logic expo_done_q;
    logic accept;

    // A frame stays active from exposure start until readout completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            readout_busy_q <= 1'b0;
            expo_done_q <= 1'b1;
        end else begin
            if (rb_pulse) begin
                readout_busy_q <= 1'b1;
            end else if (rd_pulse) begin
                readout_busy_q <= 1'b0;
            end
            if (state_q == ST_EXPOSE && count_q == 32'h0000_0000) begin
                expo_done_q <= 1'b1;
            end else if (exposure_start) begin
                expo_done_q <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (retrigger_policy)
            POL_READOUT: accept = state_q == ST_IDLE && (readout_busy_q || expo_done_q);
            POL_EXPO_END: accept = state_q == ST_IDLE && expo_done_q;
            default: accept = state_q == ST_IDLE && expo_done_q && !readout_busy_q;
        endcase
    end

    // Rejections are dropped; level triggers also need acceptance
    wire take = trig_req && accept && frames_left_q == 16'h0000;
    wire free_run = !trigger_enable_switch && !sw_fire_command_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            invalid_count_q <= 32'h0000_0000;
            invalid_trigger_event <= 1'b0;
        end else begin
            invalid_trigger_event <= 1'b0;
            if (trig_req && !level_mode && sync_align && !take && !readout_busy_q) begin
                invalid_trigger_event <= 1'b1;
                invalid_count_q <= invalid_count_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            count_q <= 32'h0000_0000;
            frames_left_q <= 16'h0000;
            exposure_start <= 1'b0;
            exposure_active <= 1'b0;
        end else begin
            exposure_start <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        frames_left_q <= kind_burst ? burst_frame_total_q : 16'h0001;
                        count_q <= 32'(fire_latency_q) * 32'(CYC_PER_US);
                        state_q <= ST_DELAY;
                    end else if (free_run && count_q >= free_period_q) begin
                        frames_left_q <= 16'h0001;
                        count_q <= 32'h0000_0000;
                        state_q <= ST_DELAY;
                    end else if (free_run || frames_left_q != 16'h0000) begin
                        count_q <= count_q + 32'h0000_0001;
                        if (frames_left_q != 16'h0000 && expo_done_q && !readout_busy_q) begin
                            count_q <= 32'h0000_0000;
                            state_q <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    if (count_q != 32'h0000_0000) begin
                        count_q <= count_q - 32'h0000_0001;
                    end else if (readout_busy_q && retrigger_policy == POL_EXPO_END) begin
                        state_q <= ST_HOLD;
                    end else begin
                        exposure_start <= 1'b1;
                        exposure_active <= 1'b1;
                        frames_left_q <= frames_left_q - 16'h0001;
                        count_q <= free_expo_q;
                        state_q <= ST_EXPOSE;
                    end
                end
                ST_HOLD: begin
                    // Exposure held back so it cannot end inside the previous readout
                    if (!readout_busy_q || rd_pulse) begin
                        exposure_start <= 1'b1;
                        exposure_active <= 1'b1;
                        frames_left_q <= frames_left_q - 16'h0001;
                        count_q <= free_expo_q;
                        state_q <= ST_EXPOSE;
                    end
                end
                ST_EXPOSE: begin
                    if (count_q == 32'h0000_0000) begin
                        exposure_active <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        count_q <= count_q - 32'h0000_0001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// ==== rtl/trig_pkg.sv ====
// Shared constants and types for the frame trigger controller
package trig_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BURST_OFS = 8'h04;
    localparam logic [7:0] DELAY_OFS = 8'h08;
    localparam logic [7:0] FIRE_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] FREE_PERIOD_OFS = 8'h14;
    localparam logic [7:0] FREE_EXPO_OFS = 8'h18;

    // Control field positions
    localparam int KIND_BIT = 0;
    localparam int ENABLE_BIT = 1;
    localparam int ORIGIN_LSB = 2;
    localparam int SENSE_LSB = 4;
    localparam int POLICY_LSB = 7;
    localparam int INVERT_BIT = 9;
    localparam int SYNC_ALIGN_BIT = 10;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] BURST_RST = 16'h0001;
    localparam logic [23:0] DELAY_RST = 24'h00_0000;
    localparam logic [31:0] FREE_PERIOD_RST = 32'h0000_1000;
    localparam logic [31:0] FREE_EXPO_RST = 32'h0000_0400;

    // Timing
    localparam int CLK_MHZ = 40;
    localparam int US_NS = 1000;
    localparam int CLK_NS = 25;
    localparam int CYC_PER_US = US_NS / CLK_NS;

    typedef enum logic [1:0] {
        ORG_LINK = 2'd0,
        ORG_SW = 2'd1,
        ORG_TIMER = 2'd2,
        ORG_COUNTER = 2'd3
    } origin_t;

    typedef enum logic [2:0] {
        SENSE_RISE = 3'd0,
        SENSE_FALL = 3'd1,
        SENSE_BOTH = 3'd2,
        SENSE_HIGH = 3'd3,
        SENSE_LOW = 3'd4
    } sense_t;

    typedef enum logic [1:0] {
        POL_OFF = 2'd0,
        POL_READOUT = 2'd1,
        POL_EXPO_END = 2'd2
    } policy_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_EXPOSE = 4'b0100,
        ST_HOLD = 4'b1000
    } fsm_t;

endpackage

// ==== testbench/frame_trigger_control_bench.sv ====
// Self-checking bench for the frame trigger controller
`timescale 1ns/1ps
module frame_trigger_control_bench;
    import trig_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic want = 1'b0, tmr = 1'b0, cev = 1'b0, ro_begin = 1'b0, ro_done = 1'b0, ro_busy = 1'b0;
    logic [1:0] lag = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, line, estart, eactive, inv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0, n_tests = 0, n_start = 0, n_inv = 0, t;
    integer seed = 32'h7e21;
    logic [1:0] r;
    logic [31:0] d, e;
    frame_trigger_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link_trigger_line(line), .timer_one_expiry(tmr),
        .counter_one_expiry(cev), .readout_begin(ro_begin), .readout_done(ro_done),
        .exposure_start(estart), .exposure_active(eactive), .invalid_trigger_event(inv));
    grabber_model grabber (.aclk(aclk), .want_level(want), .lag(lag),
        .link_trigger_line(line));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    function automatic logic [31:0] ctl(int k, int o, int s, int p, int v, int y);
        return 32'(k) << KIND_BIT | 32'h2 | 32'(o) << ORIGIN_LSB | 32'(s) << SENSE_LSB
            | 32'(p) << POLICY_LSB | 32'(v) << INVERT_BIT | 32'(y) << SYNC_ALIGN_BIT;
    endfunction
    // Effective level after the change decides whether a frame must start
    function automatic logic [31:0] hit(int s, int e);
        return (s == 0 || s == 3) ? 32'(e) : (s == 2) ? 32'h1 : 32'(!e);
    endfunction
    task give_verdict;
        $display("compared %0d, mismatched %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Sensor stand-in: readout follows each exposure that ends while no readout is running
    initial forever begin
        @(negedge eactive);
        cyc(2);
        ro_begin <= 1'b1;
        ro_busy = 1'b1;
        cyc(2);
        ro_begin <= 1'b0;
        cyc(30);
        ro_done <= 1'b1;
        cyc(2);
        ro_done <= 1'b0;
        ro_busy = 1'b0;
    end
    always @(posedge aclk) begin
        if (estart === 1'b1) n_start++;
        if (inv === 1'b1) n_inv++;
    end
    initial begin
        cyc(40000);
        n_errors++;
        give_verdict;
    end
    initial begin
        cyc(3);
        aresetn <= 1'b1;
        cyc(2);
        rd(BURST_OFS);
        check(d, 32'(BURST_RST));
        rd(FREE_PERIOD_OFS);
        check(d, FREE_PERIOD_RST);
        rd(8'h1C);
        check({d[29:0], r}, 32'h0000_0002);
        wr(STATUS_OFS, 32'h0000_0001);
        check(32'(r), 32'h0000_0002);
        repeat (3) begin
            e = $random(seed);
            wr(DELAY_OFS, e);
            rd(DELAY_OFS);
            check(d, e & 32'h00FF_FFFF);
        end
        $display("test registers ended");
        wr(FREE_EXPO_OFS, 32'h0000_0014);
        wr(DELAY_OFS, 32'h0000_0002);
        wr(CTRL_OFS, ctl(0, ORG_LINK, 0, 0, 0, 0));
        cyc(100);
        wr(FIRE_OFS, 32'h0000_0001);
        t = 0;
        while (estart !== 1'b1 && t < 300) begin
            cyc(1);
            t++;
        end
        check(32'(t >= 2 * CYC_PER_US && t <= 2 * CYC_PER_US + 10), 32'h1);
        wr(DELAY_OFS, 32'h0000_0000);
        for (int o = 0; o < 4; o++) begin
            wr(CTRL_OFS, ctl(0, o, SENSE_RISE, POL_OFF, 0, 0));
            cyc(150);
            n_start = 0;
            want <= 1'b1;
            cyc(150);
            want <= 1'b0;
            cyc(150);
            check(n_start, 32'(o == 0));
            n_start = 0;
            tmr <= 1'b1;
            cyc(3);
            tmr <= 1'b0;
            cyc(150);
            check(n_start, 32'(o == 2));
            n_start = 0;
            cev <= 1'b1;
            cyc(3);
            cev <= 1'b0;
            cyc(150);
            check(n_start, 32'(o == 3));
        end
        $display("test origins ended");
        for (int s = 0; s < 5; s++) for (int v = 0; v < 2; v++) if (s < 3 || v == 0) begin
            wr(CTRL_OFS, ctl(0, ORG_LINK, s, POL_OFF, v, 0));
            cyc(150);
            for (int ph = 1; ph >= 0; ph--) begin
                lag <= 2'($random(seed));
                want <= ph[0];
                n_start = 0;
                cyc(12);
                if (s > 2) n_start = 0;
                cyc(150);
                check(32'(n_start != 0), hit(s, ph ^ v));
            end
        end
        $display("test sense ended");
        e = 32'(2 + {$random(seed)} % 3);
        wr(BURST_OFS, e);
        wr(CTRL_OFS, ctl(1, ORG_SW, 0, 0, 0, 0));
        cyc(150);
        n_start = 0;
        wr(FIRE_OFS, 32'h0000_0001);
        cyc(500);
        check(n_start, e);
        for (int p = 0; p < 3; p++) begin
            wr(CTRL_OFS, ctl(0, ORG_SW, 0, p, 0, 0));
            cyc(150);
            n_start = 0;
            wr(FIRE_OFS, 32'h0000_0001);
            t = 0;
            while (!ro_busy && t < 300) begin
                cyc(1);
                t++;
            end
            cyc(4);
            wr(FIRE_OFS, 32'h0000_0001);
            cyc(300);
            check(n_start, (p == 0) ? 32'h1 : 32'h2);
        end
        $display("test burst and overlap ended");
        wr(CTRL_OFS, ctl(0, ORG_LINK, 0, POL_OFF, 0, 1));
        cyc(150);
        n_start = 0;
        n_inv = 0;
        wr(FIRE_OFS, 32'h0000_0001);
        cyc(2);
        want <= 1'b1;
        cyc(200);
        want <= 1'b0;
        cyc(100);
        check(n_inv, 32'h1);
        check(n_start, 32'h1);
        rd(STATUS_OFS);
        check(d, 32'h0010_0001);
        $display("test alignment ended");
        wr(FREE_PERIOD_OFS, 32'h0000_0064);
        wr(CTRL_OFS, 32'h0000_0000);
        cyc(300);
        n_start = 0;
        cyc(1000);
        // Period is the idle gap plus one delay cycle plus the exposure
        check(32'(n_start >= 1000 / 123 && n_start <= 1000 / 123 + 1), 32'h1);
        $display("test free run ended");
        give_verdict;
    end
endmodule

// ==== testbench/grabber_model.sv ====
// Frame grabber model driving the link trigger line
`timescale 1ns/1ps
module grabber_model (
    // Clock
    input wire logic aclk,
    // Request from the bench
    input wire logic want_level,
    input wire logic [1:0] lag,
    // Link side
    output logic link_trigger_line
);
    logic line_q = 1'b0;
    logic [1:0] wait_q = 2'h0;
    // A real link adds a few cycles of skew, so the level follows late
    always @(posedge aclk) begin
        if (want_level == line_q) begin
            wait_q <= lag;
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else begin
            line_q <= want_level;
        end
    end
    assign link_trigger_line = line_q;
endmodule

// ==== testbench/trig_checker.sv ====
// Assertion checker for the frame trigger controller
`timescale 1ns/1ps
module trig_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frame control
    input wire logic exposure_start,
    input wire logic exposure_active,
    input wire logic invalid_trigger_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    write_answer_a:
        assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    read_answer_a:
        assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    refused_zero_a:
        assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read carries data");
    start_pulse_a:
        assert property (exposure_start |=> !exposure_start) else $error("start pulse too long");
    start_active_a:
        assert property (exposure_start |-> ##[0:1] exposure_active) else $error("no exposure");
    invalid_pulse_a:
        assert property (invalid_trigger_event |=> !invalid_trigger_event)
        else $error("invalid event too long");
endmodule
bind frame_trigger_control trig_checker chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .exposure_start(exposure_start),
    .exposure_active(exposure_active), .invalid_trigger_event(invalid_trigger_event));
